// ---- core/rtc_regs_consts.vh ----
// constants for the alarm, timer, temperature and user byte register bank
// Operation
// (RL1) The weekday match field holds a BCD weekday 1..7 in bits 2..0, bits 6..3 unused.
// (RL2) Bit 7 of the weekday match register includes the weekday in the alarm compare when 1.
// (RL3) The month match field holds a BCD month 1..12 in bits 4..0, bits 6..5 unused.
// (RL4) Bit 7 of the month match register enables the month compare when 1.
// (RL5) The year match register holds a BCD year 0..79 in bits 6..0 and bit 7 enables it.
// (RL6) The countdown value is a 16-bit binary value, low byte at 18h, high byte at 19h.
// (RL7) The temperature code is unsigned binary, 0 is -60 C, 60 is 0 C, 250 is +190 C.
// (RL8) During a host access the temperature register is served from a frozen copy.
// (RL9) The host may write the temperature register only while the thermometer is disabled.
// (RL10) Two user bytes at 28h and 29h take any value and are held without power.
// (RL11) On the first match of all enabled fields with alarm irq enabled, set alarm flag and drive int low.
// (RL12) Fields whose enable bit is 0 are left out of the combined alarm compare.
// (RL13) Unused bits of the match registers read as zero and ignore writes.
`ifndef RTC_REGS_CONSTS_VH
`define RTC_REGS_CONSTS_VH

`define ADDR_WEEKDAY_MATCH   8'h14
`define ADDR_MONTH_MATCH     8'h15
`define ADDR_YEAR_MATCH      8'h16
`define ADDR_COUNTDOWN_LOW   8'h18
`define ADDR_COUNTDOWN_HIGH  8'h19
`define ADDR_TEMPERATURE     8'h20
`define ADDR_USER_NV0        8'h28
`define ADDR_USER_NV1        8'h29

`define MATCH_EN_BIT         7
`define WEEKDAY_MASK         8'h87
`define MONTH_MASK           8'h9F
`define YEAR_MASK            8'hFF
`define WEEKDAY_VAL_MASK     8'h07
`define MONTH_VAL_MASK       8'h1F
`define YEAR_VAL_MASK        8'h7F

`define BYTE_ZERO            8'h00
`define TEMP_ZERO_C_CODE     8'h3C
`define USER_NV_DEPTH        2

`endif

// ---- core/alarm_match.v ----
// combined alarm comparison over weekday, month and year fields
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs_consts.vh"
module alarm_match (
    input  wire [7:0] weekday_match,
    input  wire [7:0] month_match,
    input  wire [7:0] year_match,
    input  wire [7:0] cur_weekday,
    input  wire [7:0] cur_month,
    input  wire [7:0] cur_year,
    output wire       all_match
);
    // a disabled field always passes
    function field_ok;
        input [7:0] cfg;
        input [7:0] cur;
        input [7:0] vmask;
        begin
            field_ok = ~cfg[`MATCH_EN_BIT] | ((cfg & vmask) == (cur & vmask)); // [RL12]
        end
    endfunction

    wire any_en;
    assign any_en = weekday_match[`MATCH_EN_BIT] | month_match[`MATCH_EN_BIT]
                  | year_match[`MATCH_EN_BIT];
    // with nothing enabled the alarm never fires
    assign all_match = any_en
        & field_ok(weekday_match, cur_weekday, `WEEKDAY_VAL_MASK) // [RL1] [RL2]
        & field_ok(month_match, cur_month, `MONTH_VAL_MASK)       // [RL3] [RL4]
        & field_ok(year_match, cur_year, `YEAR_VAL_MASK);         // [RL5]
endmodule // alarm_match
`default_nettype wire

// ---- core/user_nv_store.v ----
// two-byte user data store
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs_consts.vh"
module user_nv_store #(
    parameter DEPTH = `USER_NV_DEPTH
) (
    input  wire       clk,
    input  wire       wr_en,
    input  wire       wr_sel,
    input  wire [7:0] wr_data,
    input  wire       rd_sel,
    output wire [7:0] rd_data
);
    // no reset: models non-volatile cells that keep content across resets
    reg [7:0] mem_ff [0:DEPTH-1];

    always @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_sel] <= wr_data; // [RL10]
        end
    end

    assign rd_data = mem_ff[rd_sel];
endmodule // user_nv_store
`default_nettype wire

// ---- core/rtc_alarm_timer_temp_regs.v ----
// register bank: upper alarm fields, countdown reload, temperature, user bytes
`timescale 1ns/100ps
`default_nettype none
`include "rtc_regs_consts.vh"
module rtc_alarm_timer_temp_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        acc_active,
    input  wire        wr_stb,
    input  wire        rd_stb,
    input  wire [7:0]  addr,
    input  wire [7:0]  wr_data,
    input  wire        therm_en,
    input  wire        meas_valid,
    input  wire [7:0]  meas_temp,
    input  wire [7:0]  cur_weekday,
    input  wire [7:0]  cur_month,
    input  wire [7:0]  cur_year,
    input  wire        alarm_irq_en,
    input  wire        alarm_flag_clr,
    output reg  [7:0]  rd_data_ff,
    output reg  [15:0] countdown_ff,
    output reg  [7:0]  temperature_ff,
    output reg         alarm_flag_ff,
    output reg         int_n_ff
);
    // ************************************************************
    // registers
    // ************************************************************
    reg  [7:0] weekday_match_ff;
    reg  [7:0] month_match_ff;
    reg  [7:0] year_match_ff;
    reg  [7:0] temp_cache_ff;
    reg        acc_active_d_ff;
    reg        match_d_ff;
    wire       all_match;
    wire [7:0] nv_rd;
    wire       nv_hit;
    wire       nv_wr;
    wire       temp_wr_ok;
    wire       match_rise;
    reg  [7:0] nxt_rd_data;

    assign nv_hit     = (addr == `ADDR_USER_NV0) | (addr == `ADDR_USER_NV1);
    assign nv_wr      = wr_stb & nv_hit;
    assign temp_wr_ok = wr_stb & (addr == `ADDR_TEMPERATURE) & ~therm_en; // [RL9]
    assign match_rise = all_match & ~match_d_ff;

    alarm_match u_match (
        .weekday_match (weekday_match_ff),
        .month_match   (month_match_ff),
        .year_match    (year_match_ff),
        .cur_weekday   (cur_weekday),
        .cur_month     (cur_month),
        .cur_year      (cur_year),
        .all_match     (all_match)
    );

    user_nv_store #(.DEPTH(`USER_NV_DEPTH)) u_nv (
        .clk     (clk),
        .wr_en   (nv_wr),
        .wr_sel  (addr[0]),
        .wr_data (wr_data),
        .rd_sel  (addr[0]),
        .rd_data (nv_rd)
    );

    // ************************************************************
    // host writes
    // ************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            weekday_match_ff <= `BYTE_ZERO;
            month_match_ff   <= `BYTE_ZERO;
            year_match_ff    <= `BYTE_ZERO;
            countdown_ff     <= {`BYTE_ZERO, `BYTE_ZERO};
        end else if (wr_stb) begin
            case (addr)
                `ADDR_WEEKDAY_MATCH:  weekday_match_ff <= wr_data & `WEEKDAY_MASK; // [RL1] [RL2] [RL13]
                `ADDR_MONTH_MATCH:    month_match_ff   <= wr_data & `MONTH_MASK;   // [RL3] [RL4] [RL13]
                `ADDR_YEAR_MATCH:     year_match_ff    <= wr_data & `YEAR_MASK;    // [RL5]
                `ADDR_COUNTDOWN_LOW:  countdown_ff[7:0]  <= wr_data;               // [RL6]
                `ADDR_COUNTDOWN_HIGH: countdown_ff[15:8] <= wr_data;               // [RL6]
                default: ;
            endcase
        end
    end

    // ************************************************************
    // temperature: live value plus frozen copy for the host
    // ************************************************************
    always @(posedge clk) begin
        if (!rst_n) begin
            temperature_ff  <= `TEMP_ZERO_C_CODE;
            temp_cache_ff   <= `TEMP_ZERO_C_CODE;
            acc_active_d_ff <= 1'b0;
        end else begin
            acc_active_d_ff <= acc_active;
            if (temp_wr_ok) begin
                temperature_ff <= wr_data; // [RL9]
            end else if (therm_en && meas_valid) begin
                temperature_ff <= meas_temp; // [RL7]
            end
            // cache follows the live value between accesses; a host temperature write loads it at any time
            if (temp_wr_ok) begin
                temp_cache_ff <= wr_data;
            end else if (!acc_active) begin
                temp_cache_ff <= temperature_ff; // [RL8]
            end
        end
    end

    // ************************************************************
    // read mux
    // ************************************************************
    always @* begin
        case (addr)
            `ADDR_WEEKDAY_MATCH:  nxt_rd_data = weekday_match_ff;
            `ADDR_MONTH_MATCH:    nxt_rd_data = month_match_ff;
            `ADDR_YEAR_MATCH:     nxt_rd_data = year_match_ff;
            `ADDR_COUNTDOWN_LOW:  nxt_rd_data = countdown_ff[7:0];
            `ADDR_COUNTDOWN_HIGH: nxt_rd_data = countdown_ff[15:8];
            `ADDR_TEMPERATURE:    nxt_rd_data = temp_cache_ff; // [RL8]
            `ADDR_USER_NV0:       nxt_rd_data = nv_rd;          // [RL10]
            `ADDR_USER_NV1:       nxt_rd_data = nv_rd;          // [RL10]
            default:              nxt_rd_data = `BYTE_ZERO;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            rd_data_ff <= `BYTE_ZERO;
        end else if (rd_stb) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ************************************************************
    // alarm flag and interrupt
    // ************************************************************
    // set wins over a clear arriving in the same cycle
    always @(posedge clk) begin
        if (!rst_n) begin
            match_d_ff    <= 1'b0;
            alarm_flag_ff <= 1'b0;
            int_n_ff      <= 1'b1;
        end else begin
            match_d_ff <= all_match;
            if (match_rise && alarm_irq_en) begin
                alarm_flag_ff <= 1'b1; // [RL11] [RL12]
                int_n_ff      <= 1'b0; // [RL11]
            end else if (alarm_flag_clr) begin
                alarm_flag_ff <= 1'b0;
                int_n_ff      <= 1'b1;
            end
        end
    end
endmodule // rtc_alarm_timer_temp_regs
`default_nettype wire

// ---- dv/regs_chk.sv ----
// port assertions for the alarm, countdown and temperature register bank
`timescale 1ns/100ps
`default_nettype none
module regs_chk (
    input wire logic        clk, rst_n, wr_stb, rd_stb, therm_en, meas_valid,
    input wire logic        alarm_flag_clr, alarm_flag_ff, int_n_ff,
    input wire logic [7:0]  addr, wr_data, rd_data_ff, temperature_ff,
    input wire logic [15:0] countdown_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    cnt_low_a: assert property (wr_stb && addr == 8'h18 |=> countdown_ff[7:0] == $past(wr_data))
        else $error("countdown low byte not loaded");
    cnt_high_a: assert property (wr_stb && addr == 8'h19 |=> countdown_ff[15:8] == $past(wr_data))
        else $error("countdown high byte not loaded");
    temp_write_a: assert property (wr_stb && addr == 8'h20 && !therm_en |=> temperature_ff == $past(wr_data))
        else $error("temperature write lost");
    temp_lock_a: assert property (wr_stb && addr == 8'h20 && therm_en && !meas_valid |=> $stable(temperature_ff))
        else $error("temperature written while measuring");
    wkday_spare_a: assert property (rd_stb && addr == 8'h14 |=> rd_data_ff[6:3] == 4'h0)
        else $error("weekday spare bits not zero");
    month_spare_a: assert property (rd_stb && addr == 8'h15 |=> rd_data_ff[6:5] == 2'h0)
        else $error("month spare bits not zero");
    int_flag_a: assert property (!int_n_ff |-> alarm_flag_ff)
        else $error("interrupt low without flag");
    flag_keep_a: assert property (alarm_flag_ff && !alarm_flag_clr |=> alarm_flag_ff)
        else $error("alarm flag dropped without clear");
endmodule // regs_chk
bind rtc_alarm_timer_temp_regs regs_chk chk (.*);
`default_nettype wire

// ---- dv/host_model.sv ----
// host side model issuing register strobes
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rd_data_ff,
    output logic            acc_active, wr_stb, rd_stb,
    output logic      [7:0] addr, wr_data
);
    logic keep = 1'b0;
    initial begin
        {acc_active, wr_stb, rd_stb} = 3'h0;
        {addr, wr_data} = 16'h0000;
    end
    task automatic sess(input logic on);
        @(negedge clk) keep = on;
        acc_active = on;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clk) acc_active = 1'b1;
        {wr_stb, rd_stb, addr, wr_data} = {wr, !wr, a, d};
        @(negedge clk) {wr_stb, rd_stb} = 2'h0;
        // released lines flip so a stale value never looks valid
        {addr, wr_data} = {~a, ~d};
        acc_active = keep;
        @(negedge clk) q = rd_data_ff;
    endtask
endmodule // host_model
`default_nettype wire

// ---- dv/rtc_alarm_timer_temp_regs_test.sv ----
// self-checking bench for the register bank
`timescale 1ns/100ps
`default_nettype none
module rtc_alarm_timer_temp_regs_test;
    logic clk = 1'b0, rst_n = 1'b0, therm_en = 1'b1, meas_valid = 1'b0;
    logic alarm_irq_en = 1'b1, alarm_flag_clr = 1'b0, acc_active, wr_stb, rd_stb, alarm_flag_ff, int_n_ff;
    logic [7:0] meas_temp = 8'h3C, cur_weekday = 8'h03, cur_month = 8'h01, cur_year = 8'h79, q;
    logic [7:0] addr, wr_data, rd_data_ff, temperature_ff;
    logic [15:0] countdown_ff;
    int failures = 0;
    int checks_done = 0;
    // address, written byte, byte read back
    logic [23:0] rows [12] = '{24'h14FF87, 24'h140505, 24'h15FF9F, 24'h151212, 24'h16FFFF, 24'h167979,
                               24'h183434, 24'h191212, 24'h280000, 24'h28FFFF, 24'h29A5A5, 24'h175A00};
    rtc_alarm_timer_temp_regs DUT (.*);
    host_model host (.*);
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [15:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ************************
    // main sequence
    // ************************
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(countdown_ff, 16'h0000, "countdown reset");
        chk(temperature_ff, 8'h3C, "temperature reset");
        chk({alarm_flag_ff, int_n_ff}, 2'h1, "alarm reset");
        foreach (rows[i]) begin
            host.xfer(1'b1, rows[i][23:16], rows[i][15:8], q);
            host.xfer(1'b0, rows[i][23:16], 8'h00, q);
            chk(q, rows[i][7:0], "readback");
        end
        chk(countdown_ff, 16'h1234, "countdown bytes");
        @(negedge clk) {meas_valid, meas_temp} = {1'b1, 8'hFA};
        @(negedge clk) meas_valid = 1'b0;
        chk(temperature_ff, 8'hFA, "measured code");
        host.xfer(1'b1, 8'h20, 8'h11, q);
        chk(temperature_ff, 8'hFA, "write while measuring");
        therm_en = 1'b0;
        host.xfer(1'b1, 8'h20, 8'h00, q);
        chk(temperature_ff, 8'h00, "host temperature write");
        therm_en = 1'b1;
        host.sess(1'b1);
        @(negedge clk) meas_valid = 1'b1;
        @(negedge clk) meas_valid = 1'b0;
        host.xfer(1'b0, 8'h20, 8'h00, q);
        host.sess(1'b0);
        chk(q, 8'h00, "frozen during access");
        chk(temperature_ff, 8'hFA, "live value moves on");
        // month and year hold values but stay out of the compare
        host.xfer(1'b1, 8'h14, 8'h83, q);
        chk({alarm_flag_ff, int_n_ff}, 2'h2, "weekday alarm");
        @(negedge clk) alarm_flag_clr = 1'b1;
        @(negedge clk) alarm_flag_clr = 1'b0;
        @(negedge clk);
        chk({alarm_flag_ff, int_n_ff}, 2'h1, "held match stays quiet");
        host.xfer(1'b1, 8'h15, 8'h92, q);
        chk(alarm_flag_ff, 1'b0, "month mismatch blocks");
        cur_month = 8'h12;
        repeat (2) @(negedge clk);
        chk(alarm_flag_ff, 1'b1, "month match raises");
        // a fresh rising match with the irq enable low must leave the flag alone
        @(negedge clk) {alarm_flag_clr, alarm_irq_en} = 2'h2;
        @(negedge clk) {alarm_flag_clr, cur_month} = {1'b0, 8'h01};
        @(negedge clk) cur_month = 8'h12;
        repeat (2) @(negedge clk);
        chk({alarm_flag_ff, int_n_ff}, 2'h1, "irq disabled stays quiet");
        // mid-run reset: match registers clear, user bytes survive
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        host.xfer(1'b0, 8'h29, 8'h00, q);
        chk(q, 8'hA5, "user byte kept over reset");
        host.xfer(1'b0, 8'h14, 8'h00, q);
        chk(q, 8'h00, "weekday match reset");
        test_done;
    end
endmodule // rtc_alarm_timer_temp_regs_test
`default_nettype wire
